// >>> core/amr_pkg.sv
// Package with offsets, field positions, reset values and codes of the misc control bank.
package amr_pkg;
	// Register offsets on the control port.
	localparam logic [7:0] AMR_OFS_CONVERTER_TUNING = 8'h5D;
	localparam logic [7:0] AMR_OFS_AUX_PIN_DIRECTION = 8'h60;
	localparam logic [7:0] AMR_OFS_AUX_PIN_FUNCTION = 8'h61;
	localparam logic [7:0] AMR_OFS_PROCESSING_BYPASS = 8'h66;
	localparam logic [7:0] AMR_OFS_SILICON_IDENTIFIER = 8'h67;
	localparam logic [7:0] AMR_OFS_OPERATING_STATE_REPORT = 8'h68;
	localparam logic [7:0] AMR_OFS_SILENCE_MUTE_STATUS = 8'h69;
	localparam logic [7:0] AMR_OFS_PWM_PHASE_SETUP = 8'h6A;
	// Reset values.
	localparam logic [7:0] AMR_RST_CONVERTER_TUNING = 8'hF8;
	localparam logic [7:0] AMR_RST_AUX_PIN_DIRECTION = 8'h00;
	localparam logic [7:0] AMR_RST_AUX_PIN_FUNCTION = 8'h00;
	localparam logic [7:0] AMR_RST_PROCESSING_BYPASS = 8'h00;
	localparam logic [7:0] AMR_RST_PWM_PHASE_SETUP = 8'h00;
	localparam logic [7:0] AMR_RST_STATUS = 8'h00;
	// Converter tuning field positions.
	localparam int AMR_POS_RATE_SEL = 7;
	localparam int AMR_POS_DITHER_EN = 5;
	localparam int AMR_POS_DITHER_LEVEL = 2;
	localparam int AMR_POS_ELEMENT_MATCHING_SELECT = 0;
	// Auxiliary pin fields.
	localparam int AMR_POS_AUX_DIR = 0;
	localparam int AMR_POS_AUX_FUNC = 0;
	// Processing bypass fields.
	localparam int AMR_POS_COEF_SHARE = 3;
	localparam int AMR_POS_BYPASS_COMPRESS = 1;
	localparam int AMR_POS_BYPASS_EQ = 0;
	// Phase setup fields.
	localparam int AMR_POS_RAMP_PHASE = 2;
	localparam int AMR_POS_SERIAL_SYNC = 1;
	localparam int AMR_POS_RAMP_SYNC = 0;
	// Mute status fields.
	localparam int AMR_POS_RIGHT_MUTE = 1;
	localparam int AMR_POS_LEFT_MUTE = 0;
	// Converter rates in kHz for the two rate select values.
	localparam int AMR_RATE_FAST_KHZ = 6144;
	localparam int AMR_RATE_SLOW_KHZ = 3072;
	// Element matching select codes.
	localparam logic [1:0] AMR_DEM_ON = 2'h0;
	localparam logic [1:0] AMR_DEM_OFF = 2'h3;
	// Auxiliary pin function codes.
	localparam logic [4:0] AMR_FN_LOW = 5'h00;
	localparam logic [4:0] AMR_FN_BOTH_MUTE = 5'h03;
	localparam logic [4:0] AMR_FN_LEFT_MUTE = 5'h04;
	localparam logic [4:0] AMR_FN_RIGHT_MUTE = 5'h05;
	localparam logic [4:0] AMR_FN_CLOCK_INVALID = 5'h06;
	localparam logic [4:0] AMR_FN_RESERVED_A = 5'h07;
	localparam logic [4:0] AMR_FN_RESERVED_B = 5'h08;
	localparam logic [4:0] AMR_FN_FAULT = 5'h0B;
	// Silicon identifier; the value is arbitrary.
	localparam logic [7:0] AMR_SILICON_IDENTIFIER_VALUE = 8'h5A;
	// Operating states as reported.
	typedef enum logic [1:0] {
		AMR_ST_DEEP_SLEEP,
		AMR_ST_SLEEP,
		AMR_ST_HIGH_IMPEDANCE,
		AMR_ST_PLAY
	} amr_state_t;
endpackage : amr_pkg

// >>> core/amr_misc_regs.sv
// Misc control register bank of the amplifier: converter, auxiliary pin, processing, phase.
`timescale 1ns/1ns

// Functional notes
// - Rate bit: clear 6.144MHz, set 3.072MHz.
// - Dither enable field selects main/second stages.
// - Dither level code maps to amplitude.
// - Matching select 00 on, 11 off.
// - Direction bit: 0 input, 1 output.
// - Function code 00000 drives pin low.
// - Codes 3/4/5 carry both/left/right mute.
// - Code 00110 carries clock-invalid flag.
// - Code 01011 gives active-low fault; 7,8 reserved.
// - Coefficient share, compressor bypass, equaliser bypass bits.
// - State report reads power state.
// - Mute status: bit1 right, bit0 left.
// - Ramp phase select picks phase 0-3.
// - Serial sync bit aligns PWM to framing.
// - Ramp sync bit enables phase synchronisation.
// - Identifier register read-only, writes ignored.
module amr_misc_regs (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic left_mute_in,
	input wire logic right_mute_in,
	input wire logic clock_error_in,
	input wire logic clock_missing_in,
	input wire logic fault_active_in,
	input wire amr_pkg::amr_state_t power_state_in,
	input wire logic aux_pin_in,
	output logic aux_pin_out,
	output logic aux_pin_oe_n,
	output logic aux_pin_sample,
	output logic rate_slow_q,
	output logic [1:0] dither_stage_en_q,
	output logic [2:0] dither_level_q,
	output logic element_matching_q,
	output logic coef_share_q,
	output logic bypass_compress_q,
	output logic bypass_eq_q,
	output logic [1:0] ramp_phase_q,
	output logic serial_sync_q,
	output logic ramp_sync_q,
	output logic [7:0] dither_exp_q
);
	import amr_pkg::*;

	// Overview. The bank holds five writable byte registers and three read-only ones.
	// Writes land in the stored image on the edge that takes them; reads answer one cycle later.
	// The decoded control outputs and the auxiliary pin trail the stored image by one more
	// cycle. Reserved bits of writable registers are stored and read back as written, but
	// no logic looks at them. The read-only offsets ignore writes, and the status images
	// follow the live conditions every cycle, so software always sees fresh values.

	// Raw stored register images; reserved bits are kept so they read back as written.
	logic [7:0] tuning_q;
	logic [7:0] aux_dir_q;
	logic [7:0] aux_fn_q;
	logic [7:0] proc_q;
	logic [7:0] phase_q;
	// Status images, refreshed every cycle.
	logic [7:0] state_report_q;
	logic [7:0] mute_rpt_q;
	// Auxiliary pin flag chosen by the function field.
	logic aux_flag;

	// Write decode helper; used by every writable register.
	// The compare is on the full offset, so aliases of a register can never be written
	// through a neighbouring offset.
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	// Dither amplitude exponent: the level is minus two to the minus this value.
	function automatic logic [7:0] dither_exp(input logic [2:0] code);
		case (code)
			3'h4: dither_exp = 8'h07;
			3'h5: dither_exp = 8'h08;
			3'h6: dither_exp = 8'h09;
			3'h7: dither_exp = 8'h0A;
			3'h0: dither_exp = 8'h0D;
			3'h1: dither_exp = 8'h0E;
			3'h2: dither_exp = 8'h0F;
			default: dither_exp = 8'h10;
		endcase
	endfunction : dither_exp

	// Element matching decode: on for the on code, off for the off code, else unchanged.
	function automatic logic matching_next(input logic [1:0] code, input logic cur);
		case (code)
			AMR_DEM_ON: matching_next = 1'b1;
			AMR_DEM_OFF: matching_next = 1'b0;
			default: matching_next = cur;
		endcase
	endfunction : matching_next

	// Converter tuning register; its reset puts the slow rate, both dither stages, and matching on.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			tuning_q <= AMR_RST_CONVERTER_TUNING;
		end else if (reg_wr && hit(reg_addr, AMR_OFS_CONVERTER_TUNING)) begin
			tuning_q <= reg_wdata;
		end
	end

	// Auxiliary pin direction and function registers.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			aux_dir_q <= AMR_RST_AUX_PIN_DIRECTION;
			aux_fn_q <= AMR_RST_AUX_PIN_FUNCTION;
		end else begin
			if (reg_wr && hit(reg_addr, AMR_OFS_AUX_PIN_DIRECTION)) begin
				aux_dir_q <= reg_wdata;
			end
			if (reg_wr && hit(reg_addr, AMR_OFS_AUX_PIN_FUNCTION)) begin
				aux_fn_q <= reg_wdata;
			end
		end
	end

	// Processing bypass and phase setup registers.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			proc_q <= AMR_RST_PROCESSING_BYPASS;
			phase_q <= AMR_RST_PWM_PHASE_SETUP;
		end else begin
			if (reg_wr && hit(reg_addr, AMR_OFS_PROCESSING_BYPASS)) begin
				proc_q <= reg_wdata;
			end
			// The phase is taken whenever written; the host is expected to do so before play.
			if (reg_wr && hit(reg_addr, AMR_OFS_PWM_PHASE_SETUP)) begin
				phase_q <= reg_wdata;
			end
		end
	end

	// Operating state image; it follows the power state each cycle, so a read sees a
	// value at most one cycle old. Writes to this offset are dropped by the decode.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_report_q <= AMR_RST_STATUS;
		end else begin
			state_report_q <= {6'h00, power_state_in};
		end
	end

	// Mute status image: right channel in bit 1, left in bit 0, reserved bits zero.
	// The image is taken whole each cycle so that both flags in one read are coherent.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			mute_rpt_q <= AMR_RST_STATUS;
		end else begin
			mute_rpt_q <= AMR_RST_STATUS;
			mute_rpt_q[AMR_POS_RIGHT_MUTE] <= right_mute_in;
			mute_rpt_q[AMR_POS_LEFT_MUTE] <= left_mute_in;
		end
	end

	// Decoded control outputs. Each concern has a process of its own, so that every output
	// comes straight from a flop and a change to one field cannot disturb another.
	// The reset branches take their values from the register reset images, so a decoded
	// output never disagrees with what a host reads back from the register after reset.
	// Every decoded output trails the stored register by one cycle; the trade is one cycle
	// of latency for clean flop outputs towards the converter and modulator.

	// Converter rate select: set means the slower converter rate, clear the faster one.
	// The converter clock generator is expected to switch only at a boundary of its own,
	// so a write here never produces a runt converter clock cycle.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			// Reset leaves the converter at the slower rate.
			rate_slow_q <= AMR_RST_CONVERTER_TUNING[AMR_POS_RATE_SEL];
		end else begin
			rate_slow_q <= tuning_q[AMR_POS_RATE_SEL];
		end
	end

	// Dither stage enables: bit 0 of the field is the main stage, bit 1 the second stage.
	// Both stages run after reset; a host may turn either off on its own.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			dither_stage_en_q <= AMR_RST_CONVERTER_TUNING[AMR_POS_DITHER_EN +: 2];
		end else begin
			dither_stage_en_q <= tuning_q[AMR_POS_DITHER_EN +: 2];
		end
	end

	// Dither level code and its amplitude exponent.
	// The exponent is carried beside the raw code so that the converter needs no copy of
	// the irregular code table; both outputs always change in the same cycle.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			dither_level_q <= AMR_RST_CONVERTER_TUNING[AMR_POS_DITHER_LEVEL +: 3];
			dither_exp_q <= dither_exp(AMR_RST_CONVERTER_TUNING[AMR_POS_DITHER_LEVEL +: 3]);
		end else begin
			dither_level_q <= tuning_q[AMR_POS_DITHER_LEVEL +: 3];
			dither_exp_q <= dither_exp(tuning_q[AMR_POS_DITHER_LEVEL +: 3]);
		end
	end

	// Element matching: code 00 turns it on, code 11 turns it off.
	// Codes 01 and 10 carry no meaning; they keep the previous setting, so that a host that
	// writes a half-formed value cannot toggle the converter by accident.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			// Reset decodes the reset image, which selects matching on.
			element_matching_q <= matching_next(
				AMR_RST_CONVERTER_TUNING[AMR_POS_ELEMENT_MATCHING_SELECT +: 2], 1'b1);
		end else begin
			element_matching_q <= matching_next(tuning_q[AMR_POS_ELEMENT_MATCHING_SELECT +: 2],
				element_matching_q);
		end
	end

	// Processing controls: coefficient sharing and the two bypass switches.
	// Sharing makes the right channel reuse the left channel's coefficient set; the
	// coefficient store itself is outside this bank. Bit 2 is reserved and drives nothing.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			coef_share_q <= AMR_RST_PROCESSING_BYPASS[AMR_POS_COEF_SHARE];
			bypass_compress_q <= AMR_RST_PROCESSING_BYPASS[AMR_POS_BYPASS_COMPRESS];
			bypass_eq_q <= AMR_RST_PROCESSING_BYPASS[AMR_POS_BYPASS_EQ];
		end else begin
			coef_share_q <= proc_q[AMR_POS_COEF_SHARE];
			bypass_compress_q <= proc_q[AMR_POS_BYPASS_COMPRESS];
			bypass_eq_q <= proc_q[AMR_POS_BYPASS_EQ];
		end
	end

	// Ramp phase select: phase 0 to 3 for codes 00 to 11, to stagger several devices.
	// The modulator takes a new phase whenever it changes; a change while playing may
	// give one irregular ramp period, which is why hosts set it before play.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ramp_phase_q <= AMR_RST_PWM_PHASE_SETUP[AMR_POS_RAMP_PHASE +: 2];
		end else begin
			ramp_phase_q <= phase_q[AMR_POS_RAMP_PHASE +: 2];
		end
	end

	// Serial audio sync: when set, the PWM phase follows the incoming serial framing.
	// Clear after reset, so the modulator runs free of the audio framing.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			serial_sync_q <= AMR_RST_PWM_PHASE_SETUP[AMR_POS_SERIAL_SYNC];
		end else begin
			serial_sync_q <= phase_q[AMR_POS_SERIAL_SYNC];
		end
	end

	// Ramp phase sync: when set, the ramp phases of staggered devices are synchronised.
	// Clear after reset; the sync logic itself lives in the modulator.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ramp_sync_q <= AMR_RST_PWM_PHASE_SETUP[AMR_POS_RAMP_SYNC];
		end else begin
			ramp_sync_q <= phase_q[AMR_POS_RAMP_SYNC];
		end
	end

	// Pin flag selection; reserved and unlisted codes hold the pin low for safety.
	// The flags are taken live here and registered below, so the pin shows a condition
	// one cycle after it appears.
	always_comb begin
		aux_flag = 1'b0;
		case (aux_fn_q[AMR_POS_AUX_FUNC +: 5])
			AMR_FN_LOW: aux_flag = 1'b0;
			AMR_FN_BOTH_MUTE: aux_flag = left_mute_in & right_mute_in;
			AMR_FN_LEFT_MUTE: aux_flag = left_mute_in;
			AMR_FN_RIGHT_MUTE: aux_flag = right_mute_in;
			AMR_FN_CLOCK_INVALID: aux_flag = clock_error_in | clock_missing_in;
			AMR_FN_RESERVED_A: aux_flag = 1'b0;
			AMR_FN_RESERVED_B: aux_flag = 1'b0;
			AMR_FN_FAULT: aux_flag = ~fault_active_in;
			default: aux_flag = 1'b0;
		endcase
	end

	// Pin level. The flag is registered so the pin never glitches while the function field
	// or the live conditions settle; it costs one cycle of flag latency.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			aux_pin_out <= 1'b0;
		end else begin
			aux_pin_out <= aux_flag;
		end
	end

	// Pin direction: the enable is active low and only asserted when the direction bit says
	// output. Reset leaves the pin an input so it cannot fight an external driver.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			aux_pin_oe_n <= 1'b1;
		end else begin
			aux_pin_oe_n <= ~aux_dir_q[AMR_POS_AUX_DIR];
		end
	end

	// Pin sample: the level on the pin is registered for the rest of the chip. It is taken
	// whatever the direction, so in output mode it simply reflects the driven level.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			aux_pin_sample <= 1'b0;
		end else begin
			aux_pin_sample <= aux_pin_in;
		end
	end

	// Read port: one cycle after the strobe; unmapped offsets read zero.
	// The read data holds until the next read, so a slow host may pick it up late.
	// The identifier is a constant, so writes to its offset have nothing to change.
	// Status offsets return the images, which lag the live conditions by one cycle.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				case (reg_addr)
					AMR_OFS_CONVERTER_TUNING: reg_rdata <= tuning_q;
					AMR_OFS_AUX_PIN_DIRECTION: reg_rdata <= aux_dir_q;
					AMR_OFS_AUX_PIN_FUNCTION: reg_rdata <= aux_fn_q;
					AMR_OFS_PROCESSING_BYPASS: reg_rdata <= proc_q;
					AMR_OFS_SILICON_IDENTIFIER: reg_rdata <= AMR_SILICON_IDENTIFIER_VALUE;
					AMR_OFS_OPERATING_STATE_REPORT: reg_rdata <= state_report_q;
					AMR_OFS_SILENCE_MUTE_STATUS: reg_rdata <= mute_rpt_q;
					AMR_OFS_PWM_PHASE_SETUP: reg_rdata <= phase_q;
					default: reg_rdata <= 8'h00;
				endcase
			end
		end
	end
endmodule : amr_misc_regs

// >>> test/amr_misc_regs_assertions.sv
// Checker of the misc control bank, bound to its top module.
`timescale 1ns/1ns
module amr_misc_regs_assertions
	import amr_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic left_mute_in,
	input wire logic right_mute_in,
	input wire amr_pkg::amr_state_t power_state_in,
	input wire logic rate_slow_q,
	input wire logic [1:0] dither_stage_en_q,
	input wire logic [2:0] dither_level_q,
	input wire logic [7:0] dither_exp_q,
	input wire logic element_matching_q,
	input wire logic aux_pin_oe_n
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// Writes to the tuning register reach the converter two edges later.
	wire tw = reg_wr && reg_addr == AMR_OFS_CONVERTER_TUNING;
	property p_rate;
		tw |-> ##2 rate_slow_q == $past(reg_wdata[7], 2);
	endproperty
	a_rate: assert property (p_rate) else $error("rate select mismatch");
	property p_dither;
		tw |-> ##2 dither_stage_en_q == $past(reg_wdata[6:5], 2);
	endproperty
	a_dither: assert property (p_dither) else $error("dither enable mismatch");
	property p_exp;
		dither_exp_q == (dither_level_q[2] ? 8'h07 : 8'h0D) + dither_level_q[1:0];
	endproperty
	a_exp: assert property (p_exp) else $error("dither amplitude mismatch");
	property p_dem;
		tw && reg_wdata[1:0] == 2'h3 |-> ##2 !element_matching_q;
	endproperty
	a_dem: assert property (p_dem) else $error("matching not off");
	property p_dir;
		reg_wr && reg_addr == AMR_OFS_AUX_PIN_DIRECTION |-> ##2 aux_pin_oe_n == !$past(reg_wdata[0], 2);
	endproperty
	a_dir: assert property (p_dir) else $error("pin direction mismatch");
	property p_rvalid;
		reg_rvalid == $past(reg_rd);
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("read valid timing");
	property p_id;
		reg_rd && reg_addr == AMR_OFS_SILICON_IDENTIFIER |=> reg_rdata == AMR_SILICON_IDENTIFIER_VALUE;
	endproperty
	a_id: assert property (p_id) else $error("identifier mismatch");
	property p_mute;
		reg_rd && reg_addr == AMR_OFS_SILENCE_MUTE_STATUS |=>
			reg_rdata == {6'h00, $past(right_mute_in, 2), $past(left_mute_in, 2)};
	endproperty
	a_mute: assert property (p_mute) else $error("mute status mismatch");
	property p_state;
		reg_rd && reg_addr == AMR_OFS_OPERATING_STATE_REPORT |=>
			reg_rdata == {6'h00, $past(power_state_in, 2)};
	endproperty
	a_state: assert property (p_state) else $error("state report mismatch");
	c_tune: cover property (tw);
	c_mute: cover property (reg_rd && reg_addr == AMR_OFS_SILENCE_MUTE_STATUS);
	c_dir: cover property (!aux_pin_oe_n);
endmodule : amr_misc_regs_assertions
bind amr_misc_regs amr_misc_regs_assertions u_amr_misc_regs_assertions (.*);

// >>> test/amr_host_model.sv
// Host model that reaches the bank through its strobe port.
`timescale 1ns/1ns
module amr_host_model (
	input wire logic core_clk,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid
);
	// A lone host has no peers, so ramp and spread settings match trivially.
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// Released lines show the inverse so stale values never pass.
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask : wr
	task rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata;
		v = reg_rvalid;
	endtask : rd
endmodule : amr_host_model

// >>> test/amr_misc_regs_test.sv
// Self-checking bench of the misc control bank.
`timescale 1ns/1ns
module amr_misc_regs_test;
	import amr_pkg::*;
	logic core_clk, sys_rst, reg_wr, reg_rd, reg_rvalid, aux_pin_in, pin_ext;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, dither_exp_q;
	logic left_mute_in, right_mute_in, clock_error_in, clock_missing_in, fault_active_in;
	logic aux_pin_out, aux_pin_oe_n, aux_pin_sample, rate_slow_q, element_matching_q;
	logic coef_share_q, bypass_compress_q, bypass_eq_q, serial_sync_q, ramp_sync_q;
	logic [1:0] dither_stage_en_q, ramp_phase_q;
	logic [2:0] dither_level_q;
	amr_state_t power_state_in;
	int n_fail = 0;
	int check_count = 0;
	logic [7:0] ofs [8] = '{8'h5D, 8'h60, 8'h61, 8'h66, 8'h67, 8'h68, 8'h69, 8'h6A};
	logic [7:0] rst [8] = '{8'hF8, 8'h00, 8'h00, 8'h00, 8'h5A, 8'h00, 8'h00, 8'h00};
	// Per entry: expected pin, right mute, fault, function code.
	logic [7:0] fn [11] = '{8'hA4, 8'h25, 8'h23, 8'hA6, 8'h2B, 8'h27, 8'h28, 8'h20,
		8'hE3, 8'h8B, 8'hC5};
	// The pin resolves from whichever party drives it.
	assign aux_pin_in = aux_pin_oe_n ? pin_ext : aux_pin_out;
	amr_misc_regs u_amr_misc_regs (.*);
	amr_host_model u_amr_host_model (.*);
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	task close_out;
		if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	task chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Control outputs settle two edges after the write strobe is raised.
	task wr(input logic [7:0] a, input logic [7:0] d);
		u_amr_host_model.wr(a, d);
		repeat (2) @(posedge core_clk);
		#1;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic v;
		u_amr_host_model.rd(a, d, v);
		chk({7'h00, v}, 8'h01);
		chk(d, exp);
	endtask : rd
	initial begin
		{left_mute_in, right_mute_in, clock_error_in, clock_missing_in} = 4'h0;
		fault_active_in = 1'b0;
		pin_ext = 1'b0;
		power_state_in = AMR_ST_DEEP_SLEEP;
		sys_rst = 1'b1;
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		#1;
		chk({rate_slow_q, dither_stage_en_q, dither_level_q, element_matching_q, 1'b0}, 8'hFA);
		chk({aux_pin_oe_n, aux_pin_out, dither_exp_q[5:0]}, 8'h89);
		for (int i = 0; i < 8; i++) rd(ofs[i], rst[i]);
		rd(8'h62, 8'h00);
		for (int i = 0; i < 8; i++) begin
			wr(8'h5D, {i[0], i[1:0], i[2:0], 2'h3});
			chk({rate_slow_q, dither_stage_en_q, dither_level_q, element_matching_q, 1'b0},
				{i[0], i[1:0], i[2:0], 2'h0});
			chk(dither_exp_q, (i < 4 ? 8'h0D : 8'h03) + 8'(i));
		end
		wr(8'h5D, 8'h00);
		chk({7'h00, element_matching_q}, 8'h01);
		wr(8'h60, 8'h01);
		chk({7'h00, aux_pin_oe_n}, 8'h00);
		left_mute_in <= 1'b1;
		clock_error_in <= 1'b1;
		for (int k = 0; k < 11; k++) begin
			right_mute_in <= fn[k][6];
			fault_active_in <= fn[k][5];
			wr(8'h61, {3'h0, fn[k][4:0]});
			chk({7'h00, aux_pin_out}, {7'h00, fn[k][7]});
		end
		clock_error_in <= 1'b0;
		clock_missing_in <= 1'b1;
		wr(8'h61, 8'h06);
		chk({7'h00, aux_pin_out}, 8'h01);
		rd(8'h69, 8'h03);
		left_mute_in <= 1'b0;
		rd(8'h69, 8'h02);
		wr(8'h60, 8'h00);
		pin_ext <= 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		chk({aux_pin_oe_n, aux_pin_sample}, 8'h03);
		wr(8'h66, 8'h0B);
		chk({coef_share_q, bypass_compress_q, bypass_eq_q}, 8'h07);
		rd(8'h66, 8'h0B);
		for (int j = 0; j < 4; j++) begin
			wr(8'h6A, {4'h0, j[1:0], j[1:0]});
			chk({ramp_phase_q, serial_sync_q, ramp_sync_q}, {j[1:0], j[1:0]});
		end
		// Phase is programmed above, so play is entered last.
		for (int s = 0; s < 4; s++) begin
			power_state_in <= amr_state_t'(s);
			rd(8'h68, 8'(s));
		end
		wr(8'h67, 8'hFF);
		rd(8'h67, 8'h5A);
		wr(8'h68, 8'hFF);
		rd(8'h68, 8'h03);
		close_out();
	end
	// A hung handshake is cut short well past the expected run.
	initial begin
		#100000;
		n_fail++;
		close_out();
	end
endmodule : amr_misc_regs_test
